// ### aoot_defines.svh
// constants of the auto-off override timer: times, counts, strap values
// assumes a single 40 MHz clock domain
`ifndef AOOT_DEFINES_SVH
`define AOOT_DEFINES_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define AOOT_CLK_HZ        40000000
`define AOOT_CYC_PER_MS    (`AOOT_CLK_HZ / 1000)

// ----------------------------------------------------------------------
// override pulse thresholds, measured from the acquisition end that saw it
// ----------------------------------------------------------------------
`define AOOT_RELOAD_MS     10
`define AOOT_CANCEL_MS     50
`define AOOT_RELOAD_CYC    (`AOOT_RELOAD_MS * `AOOT_CYC_PER_MS)
`define AOOT_CANCEL_CYC    (`AOOT_CANCEL_MS * `AOOT_CYC_PER_MS)

// ----------------------------------------------------------------------
// delay values
// ----------------------------------------------------------------------
`define AOOT_SEC_PER_MIN   60
`define AOOT_SHORT_MIN     15
`define AOOT_LONG_MIN      60
`define AOOT_RC_STEP_S     15
`define AOOT_RC_MIN        4
`define AOOT_RC_MAX        240
`define AOOT_MULT_LO       1
`define AOOT_MULT_HI       24
`define AOOT_DELAY_W       17

// ----------------------------------------------------------------------
// start-up
// ----------------------------------------------------------------------
`define AOOT_SETTLE_CYC    2'h3

`endif

// ### aoot_pkg.sv
// types of the auto-off override timer
// assumes aoot_defines.svh for all numeric values
package aoot_pkg;

  // hard-wired or rc connection of the delay strap
  typedef enum logic [1:0] {
    AOOT_STRAP_OFF,
    AOOT_STRAP_ON,
    AOOT_STRAP_OUT,
    AOOT_STRAP_RC
  } aoot_strap_t;

  // override sequencing
  typedef enum logic [1:0] {
    AOOT_ST_SETTLE,
    AOOT_ST_RUN,
    AOOT_ST_HELD,
    AOOT_ST_RECAL
  } aoot_state_t;

endpackage

// ### aoot_cd_if.sv
// link between the override sequencer and the seconds countdown
// assumes one clock shared by both ends
`timescale 1ns/10ps
`include "aoot_defines.svh"

interface aoot_cd_if;
  logic                     load;
  logic                     stop;
  logic                     infinite;
  logic [`AOOT_DELAY_W-1:0] load_secs;
  logic                     expired;

  modport ctrl (output load, output stop, output infinite, output load_secs, input expired);
  modport cnt  (input load, input stop, input infinite, input load_secs, output expired);
endinterface

// ### aoot_countdown.sv
// seconds countdown for the auto-off delay
// assumes load and stop are one-cycle pulses from the sequencer
`timescale 1ns/10ps
`include "aoot_defines.svh"

module aoot_countdown #(
  parameter int unsigned SEC_CYC = `AOOT_CLK_HZ
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // sequencer side
  aoot_cd_if.cnt    cd
);

  localparam int unsigned PW = $clog2(SEC_CYC);

  logic [PW-1:0]            pre_reg,   pre_next;
  logic [`AOOT_DELAY_W-1:0] secs_reg,  secs_next;
  logic                     run_reg,   run_next;
  logic                     inf_reg,   inf_next;
  logic                     exp_reg,   exp_next;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    pre_next  = pre_reg;
    secs_next = secs_reg;
    run_next  = run_reg;
    inf_next  = inf_reg;
    exp_next  = 1'b0;
    if (cd.load) begin
      pre_next  = '0;
      secs_next = cd.load_secs;
      inf_next  = cd.infinite;
      run_next  = 1'b1;
    end else if (cd.stop) begin
      run_next = 1'b0;
    end else if (run_reg && !inf_reg) begin
      if (pre_reg == PW'(SEC_CYC - 1)) begin
        pre_next = '0;
        if (secs_reg <= `AOOT_DELAY_W'(1)) begin
          run_next = 1'b0;
          exp_next = 1'b1;
        end else begin
          secs_next = secs_reg - `AOOT_DELAY_W'(1);
        end
      end else begin
        pre_next = pre_reg + PW'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg  <= '0;
      secs_reg <= '0;
      run_reg  <= 1'b0;
      inf_reg  <= 1'b0;
      exp_reg  <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      secs_reg <= secs_next;
      run_reg  <= run_next;
      inf_reg  <= inf_next;
      exp_reg  <= exp_next;
    end
  end

  assign cd.expired = exp_reg;

endmodule // aoot_countdown

// ### aoot_timer.sv
// auto-off delay, sustain and cancel logic of a single-key toggle sensor
// assumes acquisition logic on clk supplies acq_end and touch_toggle pulses
// and the measured rc product; straps and the multiplier level are pins
`timescale 1ns/10ps
`include "aoot_defines.svh"

module aoot_timer #(
  parameter int unsigned RELOAD_CYC = `AOOT_RELOAD_CYC,
  parameter int unsigned CANCEL_CYC = `AOOT_CANCEL_CYC,
  parameter int unsigned SEC_CYC    = `AOOT_CLK_HZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // strap pins
  input  wire logic       multiplier_strap_level,
  input  wire logic [1:0] time_strap,
  // measurement of the timing network
  input  wire logic [15:0] rc_product,
  input  wire logic [7:0]  supply_k,
  // acquisition logic
  input  wire logic       acq_end,
  input  wire logic       touch_toggle,
  // status and control to acquisition logic
  output logic            out_on,
  output logic            burst_inhibit,
  output logic            touch_inhibit,
  output logic            recal_req
);

  localparam int unsigned WW = $clog2(CANCEL_CYC + 1);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {time_strap, multiplier_strap_level};
      sync2_reg <= sync1_reg;
    end
  end

  logic       mult_lvl;
  logic [1:0] time_lvl;
  assign mult_lvl = sync2_reg[0];
  assign time_lvl = sync2_reg[2:1];

  // ----------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------
  aoot_pkg::aoot_state_t  st_reg,     st_next;
  logic [1:0]             settle_reg, settle_next;
  logic                   x24_reg,    x24_next;
  aoot_pkg::aoot_strap_t  strap_reg,  strap_next;
  logic [WW-1:0]          width_reg,  width_next;
  logic                   cancel_reg, cancel_next;
  logic                   on_reg,     on_next;
  logic                   recal_reg,  recal_next;

  aoot_cd_if cd ();

  // ----------------------------------------------------------------------
  // delay computation
  // ----------------------------------------------------------------------
  logic [31:0] rc_q;
  logic [31:0] base_s;
  logic [31:0] full_s;
  logic        infinite;

  always_comb begin
    rc_q     = (supply_k == 8'h00) ? 32'(rc_product) : 32'(rc_product / supply_k);
    if (rc_q == 32'h0) begin
      rc_q = 32'h1;
    end
    base_s   = 32'h0;
    infinite = 1'b0;
    unique case (strap_reg)
      aoot_pkg::AOOT_STRAP_OFF: begin
        infinite = 1'b1;
      end
      aoot_pkg::AOOT_STRAP_ON: begin
        base_s = `AOOT_SHORT_MIN * `AOOT_SEC_PER_MIN;
      end
      aoot_pkg::AOOT_STRAP_OUT: begin
        base_s = `AOOT_LONG_MIN * `AOOT_SEC_PER_MIN;
      end
      aoot_pkg::AOOT_STRAP_RC: begin
        if (rc_product < 16'(`AOOT_RC_MIN)) begin
          base_s = `AOOT_LONG_MIN * `AOOT_SEC_PER_MIN;
        end else if (rc_product > 16'(`AOOT_RC_MAX)) begin
          infinite = 1'b1;
        end else begin
          base_s = rc_q * `AOOT_RC_STEP_S;
        end
      end
    endcase
    full_s = base_s * (x24_reg ? `AOOT_MULT_HI : `AOOT_MULT_LO);
  end

  // ----------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    settle_next  = settle_reg;
    x24_next     = x24_reg;
    strap_next   = strap_reg;
    width_next   = width_reg;
    cancel_next  = cancel_reg;
    on_next      = on_reg;
    recal_next   = 1'b0;
    cd.load      = 1'b0;
    cd.stop      = 1'b0;
    cd.infinite  = infinite;
    cd.load_secs = full_s[`AOOT_DELAY_W-1:0];
    unique case (st_reg)
      aoot_pkg::AOOT_ST_SETTLE: begin
        // let the synchronisers fill before straps are captured
        if (settle_reg == `AOOT_SETTLE_CYC) begin
          x24_next   = mult_lvl;
          strap_next = aoot_pkg::aoot_strap_t'(time_lvl);
          st_next    = aoot_pkg::AOOT_ST_RUN;
        end else begin
          settle_next = settle_reg + 2'h1;
        end
      end
      aoot_pkg::AOOT_ST_RUN: begin
        if (acq_end && (mult_lvl != x24_reg)) begin
          st_next     = aoot_pkg::AOOT_ST_HELD;
          width_next  = '0;
          cancel_next = 1'b0;
        end else if (cd.expired && on_reg) begin
          on_next = 1'b0;
        end else if (touch_toggle) begin
          on_next = !on_reg;
          if (!on_reg) begin
            cd.load = 1'b1;
          end else begin
            cd.stop = 1'b1;
          end
        end
      end
      aoot_pkg::AOOT_ST_HELD: begin
        if (mult_lvl == x24_reg) begin
          // level is back: reload only for a medium pulse
          if (!cancel_reg && (width_reg > WW'(RELOAD_CYC)) && on_reg) begin
            cd.load = 1'b1;
          end
          st_next    = aoot_pkg::AOOT_ST_RECAL;
          recal_next = 1'b1;
        end else begin
          if (width_reg != WW'(CANCEL_CYC)) begin
            width_next = width_reg + WW'(1);
          end else if (!cancel_reg) begin
            cancel_next = 1'b1;
            on_next     = 1'b0;
            cd.stop     = 1'b1;
          end
          if (cd.expired && on_reg && !cancel_reg) begin
            on_next = 1'b0;
          end
        end
      end
      aoot_pkg::AOOT_ST_RECAL: begin
        st_next = aoot_pkg::AOOT_ST_RUN;
        if (cd.expired && on_reg) begin
          on_next = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg     <= aoot_pkg::AOOT_ST_SETTLE;
      settle_reg <= 2'h0;
      x24_reg    <= 1'b0;
      strap_reg  <= aoot_pkg::AOOT_STRAP_OFF;
      width_reg  <= '0;
      cancel_reg <= 1'b0;
      on_reg     <= 1'b0;
      recal_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      settle_reg <= settle_next;
      x24_reg    <= x24_next;
      strap_reg  <= strap_next;
      width_reg  <= width_next;
      cancel_reg <= cancel_next;
      on_reg     <= on_next;
      recal_reg  <= recal_next;
    end
  end

  // ----------------------------------------------------------------------
  // seconds countdown
  // ----------------------------------------------------------------------
  aoot_countdown #(
    .SEC_CYC (SEC_CYC)
  ) u_countdown (
    .clk   (clk),
    .rst_n (rst_n),
    .cd    (cd.cnt)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign out_on        = on_reg;
  assign recal_req     = recal_reg;
  assign burst_inhibit = (st_reg == aoot_pkg::AOOT_ST_HELD) ||
                         (st_reg == aoot_pkg::AOOT_ST_SETTLE);
  assign touch_inhibit = (st_reg != aoot_pkg::AOOT_ST_RUN);

endmodule // aoot_timer

// ### aoot_timer_monitor.sv
// port assertions of the auto-off override timer
// assumes one clock and an async active-low reset
`timescale 1ns/10ps
module aoot_timer_monitor #(
  parameter int unsigned CANCEL_CYC = 2000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // acquisition strobes
  input wire logic acq_end,
  input wire logic touch_toggle,
  // status
  input wire logic out_on,
  input wire logic burst_inhibit,
  input wire logic touch_inhibit,
  input wire logic recal_req
);
  logic [2:0] rst_cnt_reg;
  logic [2:0] rst_cnt_next;
  int         held_reg;
  int         held_next;
  always_comb begin
    rst_cnt_next = rst_cnt_reg + {2'h0, rst_cnt_reg != 3'h7};
    held_next = burst_inhibit ? held_reg + 1 : 0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_reg <= 3'h0;
      held_reg <= 0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      held_reg <= held_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_settle_hold: assert property (rst_cnt_reg < 3'h4 |-> burst_inhibit)
    else $error("run before straps captured");
  a_settle_run: assert property (rst_cnt_reg == 3'h4 |-> !touch_inhibit)
    else $error("no run after settle");
  a_hold_cause: assert property ($rose(burst_inhibit) |-> $past(acq_end))
    else $error("hold without acquisition end");
  a_hold_both: assert property (burst_inhibit |-> touch_inhibit)
    else $error("touch open while held");
  a_cancel_time: assert property (held_reg > CANCEL_CYC + 3 |-> !out_on)
    else $error("long hold kept output on");
  a_touch_block: assert property (touch_inhibit && touch_toggle && !out_on |=> !out_on)
    else $error("blocked touch switched on");
  a_recal_once: assert property (recal_req |=> !recal_req && !burst_inhibit)
    else $error("recalibration not single");
  a_recal_cause: assert property ($rose(recal_req) |-> $past(burst_inhibit))
    else $error("recalibration without hold");
  cover property (recal_req);
  cover property (burst_inhibit && out_on ##1 !out_on);
  cover property ($fell(out_on) && !touch_inhibit);
endmodule // aoot_timer_monitor

bind aoot_timer aoot_timer_monitor #(.CANCEL_CYC(CANCEL_CYC)) u_mon (
  .clk(clk), .rst_n(rst_n), .acq_end(acq_end), .touch_toggle(touch_toggle),
  .out_on(out_on), .burst_inhibit(burst_inhibit), .touch_inhibit(touch_inhibit),
  .recal_req(recal_req));

// ### aoot_strap_driver.sv
// outside sustain and cancel logic on the multiplier pin
// assumes go is one cycle long with len set
`timescale 1ns/10ps
module aoot_strap_driver (
  // clock
  input wire logic clk,
  // command
  input wire logic normal,
  input wire logic go,
  input int        len,
  // pin
  output logic     level
);
  int cnt = 0;
  always @(posedge clk) begin
    if (go)
      cnt <= len;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign level = (cnt > 0) ? !normal : normal;
endmodule // aoot_strap_driver

// ### test_auto_off_override_timer.sv
// self-checking bench of the auto-off override timer
// assumes shortened counts: reload 40, cancel 200, 5 cycles a second
`timescale 1ns/10ps
module test_auto_off_override_timer;
  localparam int SC = 5;
  logic clk = 0, rst_n = 0, acq_end = 0, touch_toggle = 0, go = 0, normal = 0;
  logic [1:0] time_strap = 2'h3;
  logic [15:0] rc_product = 16'h001e;
  logic [7:0] supply_k = 8'h0f;
  logic mlev, out_on, burst_inhibit, touch_inhibit, recal_req;
  int len = 0, fails = 0, num_checks = 0, n, d, recals = 0;
  integer seed = 32'h40e92d12;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (recal_req === 1'b1) recals++;
  aoot_strap_driver u_ext (.clk(clk), .normal(normal), .go(go), .len(len), .level(mlev));
  aoot_timer #(.RELOAD_CYC(40), .CANCEL_CYC(200), .SEC_CYC(SC)) dut (
    .clk(clk), .rst_n(rst_n), .multiplier_strap_level(mlev), .time_strap(time_strap),
    .rc_product(rc_product), .supply_k(supply_k), .acq_end(acq_end),
    .touch_toggle(touch_toggle), .out_on(out_on), .burst_inhibit(burst_inhibit),
    .touch_inhibit(touch_inhibit), .recal_req(recal_req));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic touch;
    touch_toggle <= 1'b1;
    tick(1);
    touch_toggle <= 1'b0;
    tick(1);
  endtask
  task automatic wait_off(input int bound, output int k);
    k = 0;
    while (out_on !== 1'b0 && k < bound) begin
      tick(1);
      k++;
    end
    if (out_on !== 1'b0) begin
      check(out_on, 1'b0);
      stop_test();
    end
  endtask
  task automatic do_reset(input logic m, input logic [1:0] ts);
    rst_n <= 1'b0;
    normal <= m;
    time_strap <= ts;
    tick(8);
    check({burst_inhibit, touch_inhibit, out_on, recal_req}, 4'hc);
    rst_n <= 1'b1;
    tick(8);
  endtask
  // full delay in cycles, zero for no auto-off
  function automatic int exp_cyc(logic m, logic [1:0] ts, int rc, int k);
    int b;
    if (k == 0) k = 1;
    case (ts)
      2'h1: b = 900;
      2'h2: b = 3600;
      2'h3: b = rc < 4 ? 3600 : rc > 240 ? 0 : (rc / k < 1 ? 1 : rc / k) * 15;
      default: b = 0;
    endcase
    return b * (m ? 24 : 1) * SC;
  endfunction
  task automatic run_delay(input logic m, input logic [1:0] ts, input int rc, input int k);
    rc_product <= 16'(rc);
    supply_k <= 8'(k);
    d = exp_cyc(m, ts, rc, k);
    do_reset(m, ts);
    touch;
    if (d == 0) begin
      tick(3000);
      check(out_on, 1'b1);
      touch;
      check(out_on, 1'b0);
    end else begin
      wait_off(d + 20, n);
      check(n > d - 5 && n < d + 5, 1'b1);
    end
  endtask
  task automatic override(input int w);
    len <= w;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(4);
    acq_end <= 1'b1;
    tick(1);
    acq_end <= 1'b0;
    tick(1);
    check({burst_inhibit, touch_inhibit}, 2'h3);
  endtask
  initial begin
    run_delay(1'b0, 2'h0, 30, 15);
    run_delay(1'b0, 2'h1, 30, 15);
    run_delay(1'b0, 2'h2, 30, 15);
    run_delay(1'b0, 2'h3, 3, 1);
    run_delay(1'b0, 2'h3, 241, 1);
    run_delay(1'b1, 2'h3, 4, 4);
    repeat (3) run_delay(1'b0, 2'h3, $unsigned($random(seed)) % 37 + 4,
                         $unsigned($random(seed)) % 4);
    run_delay(1'b0, 2'h3, 60, 15);
    // sustain reloads the countdown
    touch;
    tick(150);
    d = recals;
    override(100);
    tick(110);
    check(recals - d, 1);
    check({out_on, touch_inhibit}, 2'h2);
    wait_off(400, n);
    check(n > 250 && n < 300, 1'b1);
    // short pulse leaves the countdown alone
    touch;
    tick(100);
    override(20);
    tick(30);
    wait_off(400, n);
    check(n > 145 && n < 185, 1'b1);
    // cancel forces off and blocks touch
    touch;
    tick(20);
    override(300);
    touch;
    check(out_on, 1'b1);
    tick(190);
    check(out_on, 1'b1);
    tick(20);
    check(out_on, 1'b0);
    touch;
    check(out_on, 1'b0);
    tick(100);
    check(touch_inhibit, 1'b0);
    touch;
    check(out_on, 1'b1);
    do_reset(1'b0, 2'h1);
    stop_test();
  end
endmodule // test_auto_off_override_timer
